// ### cfg_header_regs.sv
// configuration header bank: latency/interrupt dword and native identity,
// command and status dwords, plus target select timing
// assumes config cycles arrive one per request, synchronous to clock_in
`timescale 1ns/1ps

// Behaviour
// (RQ1) latency limit read-only, zero for emulation function
// (RQ2) minimum grant read-only, zero for emulation function
// (RQ3) interrupt pin reads one, meaning INTA
// (RQ4) interrupt line writable, resets to 0xFF
// (RQ5) line 0..0xF are IRQs, 0xFF unconnected
// (RQ6) boot software writes line; device only stores
// (RQ7) chip number field read-only fixed value
// (RQ8) function field echoes config address bits 10:8
// (RQ9) low identity half is read-only maker code
// (RQ10) status bit 30 set when error driven
// (RQ11) bit 29 master abort, write one clears
// (RQ12) bit 28 target abort, write one clears
// (RQ13) select speed field reads fast, 00
// (RQ14) fast select, medium select on retry
// (RQ15) command bit 8 gates error driver
// (RQ16) command bit 2 allows bus mastering
// (RQ17) command bit 1 enables memory response
// (RQ18) read-only writes ignored, reserved read zero
module cfg_header_regs #(
    parameter logic [12:0] CHIP_NUMBER   = 13'h0abc, // arbitrary value
    parameter logic [15:0] MAKER_CODE    = 16'h5a5a, // arbitrary value
    parameter logic [7:0]  LATENCY_LIMIT = 8'h00,
    parameter logic [7:0]  MIN_GRANT     = 8'h00
) (
    input  wire logic        clock_in,
    input  wire logic        reset_n_in,
    input  wire logic        cfg_valid_in,
    input  wire logic        cfg_write_in,
    input  wire logic [10:0] cfg_addr_in,
    input  wire logic [3:0]  cfg_be_in,
    input  wire logic [31:0] cfg_wdata_in,
    input  wire logic        serr_request_in,
    input  wire logic        master_abort_in,
    input  wire logic        special_cycle_in,
    input  wire logic        target_abort_in,
    input  wire logic        target_hit_in,
    input  wire logic        retry_in,
    output logic             cfg_ack_out,
    output logic [31:0]      cfg_rdata_out,
    output logic             serr_n_out,
    output logic             serr_oe_n_out,
    output logic             devsel_n_out,
    output logic             io_space_allow_out,
    output logic             mem_space_allow_out,
    output logic             bus_master_allow_out,
    output logic             line_write_cmd_allow_out
);
    import cfg_header_pkg::*;

    // ****************************************************************
    // decode
    // ****************************************************************
    logic [15:0] command;
    logic [7:0]  int_line;
    logic        retry_pend;
    logic [2:0]  func;
    logic        is_native;
    logic        rd_req;
    logic        wr_req;
    logic        hit_id;
    logic        hit_cs;
    logic        hit_li;
    logic        serr_drive;
    logic [15:0] cmd_wr_val;
    logic [15:0] next_command;
    logic [7:0]  next_int_line;
    logic [31:0] word_id;
    logic [31:0] word_cs;
    logic [31:0] word_li;
    logic [31:0] next_rdata;
    logic        fast_sel;
    logic        next_devsel_n;

    // other functions see only the shared latency_interrupt_cfg dword
    assign func      = cfg_addr_in[FUNC_HI:FUNC_LO];
    assign is_native = (func == NATIVE_FUNC);
    assign rd_req    = cfg_valid_in & ~cfg_write_in;
    assign wr_req    = cfg_valid_in & cfg_write_in;
    assign hit_id    = is_native & ({cfg_addr_in[7:2], 2'b00} == OFF_IDENTITY);
    assign hit_cs    = is_native & ({cfg_addr_in[7:2], 2'b00} == OFF_CMD_STATUS);
    assign hit_li    = ({cfg_addr_in[7:2], 2'b00} == OFF_LAT_INT);

    // ****************************************************************
    // status flags
    // ****************************************************************
    flag_if serr_flag ();
    flag_if mst_flag ();
    flag_if tgt_flag ();

    // driver only fires when software enabled it
    assign serr_drive      = serr_request_in & command[CMD_SERR_EN];    // see RQ15
    assign serr_flag.set   = serr_drive;                                // see RQ10
    assign mst_flag.set    = master_abort_in & ~special_cycle_in;       // see RQ11
    assign tgt_flag.set    = target_abort_in;                           // see RQ12
    // clears use the upper status byte lane only
    assign serr_flag.clear = wr_req & hit_cs & cfg_be_in[3] & cfg_wdata_in[STS_SERR];
    assign mst_flag.clear  = wr_req & hit_cs & cfg_be_in[3] & cfg_wdata_in[STS_MST_ABORT];
    assign tgt_flag.clear  = wr_req & hit_cs & cfg_be_in[3] & cfg_wdata_in[STS_TGT_ABORT];

    sticky_flag u_serr_flag (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .port       (serr_flag.keeper)
    );
    sticky_flag u_mst_flag (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .port       (mst_flag.keeper)
    );
    sticky_flag u_tgt_flag (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .port       (tgt_flag.keeper)
    );

    // ****************************************************************
    // writes
    // ****************************************************************
    // reserved command bits stay zero whatever is written
    assign cmd_wr_val = {cfg_be_in[1] ? cfg_wdata_in[15:8] : command[15:8],
                         cfg_be_in[0] ? cfg_wdata_in[7:0] : command[7:0]};
    assign next_command  = (wr_req & hit_cs) ? (cmd_wr_val & CMD_WRITE_MASK)
                                             : command;           // see RQ18
    // any byte value is stored, the line is only a note for software
    assign next_int_line = (wr_req & hit_li & cfg_be_in[0]) ? cfg_wdata_in[7:0]
                                                            : int_line; // see RQ4 see RQ6

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            command  <= CMD_RESET;
            int_line <= INT_LINE_RESET;                            // see RQ4
        end else begin
            command  <= next_command;
            int_line <= next_int_line;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    assign word_id = {CHIP_NUMBER, func, MAKER_CODE};              // see RQ7 see RQ8 see RQ9
    assign word_cs = {1'b0, serr_flag.value, mst_flag.value, tgt_flag.value, 1'b0,
                      SEL_SPEED_FAST, 9'h000, command};            // see RQ13 see RQ18
    assign word_li = {is_native ? LATENCY_LIMIT : 8'h00,           // see RQ1
                      is_native ? MIN_GRANT : 8'h00,               // see RQ2
                      INT_PIN_INTA, int_line};                     // see RQ3 see RQ5
    assign next_rdata = !rd_req ? ZERO_WORD :
                        hit_id  ? word_id :
                        hit_cs  ? word_cs :
                        hit_li  ? word_li : ZERO_WORD;             // see RQ18

    // answer one cycle after the request edge
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cfg_ack_out   <= 1'b0;
            cfg_rdata_out <= ZERO_WORD;
        end else begin
            cfg_ack_out   <= cfg_valid_in;
            cfg_rdata_out <= next_rdata;
        end
    end

    // ****************************************************************
    // target select timing and pin drivers
    // ****************************************************************
    // retry costs one more cycle so it reports as medium
    assign fast_sel      = target_hit_in & command[CMD_MEM] & ~retry_in;     // see RQ14 see RQ17
    assign next_devsel_n = ~(fast_sel | retry_pend);

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            retry_pend               <= 1'b0;
            devsel_n_out             <= 1'b1;
            serr_n_out               <= 1'b1;
            serr_oe_n_out            <= 1'b1;
            io_space_allow_out       <= 1'b0;
            mem_space_allow_out      <= 1'b0;
            bus_master_allow_out     <= 1'b0;
            line_write_cmd_allow_out <= 1'b0;
        end else begin
            retry_pend               <= target_hit_in & command[CMD_MEM] & retry_in;
            devsel_n_out             <= next_devsel_n;
            serr_n_out               <= ~serr_drive;
            serr_oe_n_out            <= ~serr_drive;                  // see RQ15
            io_space_allow_out       <= command[CMD_IO];
            mem_space_allow_out      <= command[CMD_MEM];             // see RQ17
            bus_master_allow_out     <= command[CMD_MASTER];          // see RQ16
            line_write_cmd_allow_out <= command[CMD_LINE_WRITE];
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking dflt @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    a_lat_limit_zero: assert property ( // see RQ1
        rd_req && hit_li && !is_native |=> cfg_rdata_out[31:24] == 8'h00)
        else $error("latency limit not zero for other function");
    a_min_grant_zero: assert property ( // see RQ2
        rd_req && hit_li && !is_native |=> cfg_rdata_out[23:16] == 8'h00)
        else $error("minimum grant not zero for other function");
    a_int_pin_inta: assert property ( // see RQ3
        rd_req && hit_li |=> cfg_ack_out && cfg_rdata_out[15:8] == INT_PIN_INTA)
        else $error("interrupt pin not INTA");
    a_int_line_store: assert property ( // see RQ4
        wr_req && hit_li && cfg_be_in[0] ##1 !(wr_req && hit_li) ##1 rd_req && hit_li
        |=> cfg_rdata_out[7:0] == $past(cfg_wdata_in[7:0], 3))
        else $error("interrupt line lost written value");
    a_ident_word: assert property ( // see RQ7
        rd_req && hit_id |=> cfg_rdata_out[31:19] == CHIP_NUMBER
                             && cfg_rdata_out[15:0] == MAKER_CODE)
        else $error("identity word wrong");
    a_func_echo: assert property ( // see RQ8
        rd_req && hit_id |=> cfg_rdata_out[18:16] == $past(cfg_addr_in[10:8]))
        else $error("function field does not echo address");
    a_serr_flag_set: assert property ( // see RQ10
        serr_request_in && command[CMD_SERR_EN] |=> !serr_oe_n_out && serr_flag.value)
        else $error("error driven without status flag");
    a_mst_abort_flag: assert property ( // see RQ11
        master_abort_in && !special_cycle_in |=> mst_flag.value)
        else $error("master abort not recorded");
    a_tgt_abort_flag: assert property ( // see RQ12
        target_abort_in |=> tgt_flag.value)
        else $error("target abort not recorded");
    a_sel_speed_fast: assert property ( // see RQ13
        rd_req && hit_cs |=> cfg_rdata_out[26:25] == SEL_SPEED_FAST
                             && !cfg_rdata_out[31] && !cfg_rdata_out[27])
        else $error("status reserved or speed bits wrong");
    a_devsel_medium: assert property ( // see RQ14
        target_hit_in && retry_in && command[CMD_MEM] && !retry_pend
        |=> devsel_n_out ##1 !devsel_n_out)
        else $error("retry select not medium");
    a_serr_gated: assert property ( // see RQ15
        !command[CMD_SERR_EN] |=> serr_oe_n_out)
        else $error("error driver on while disabled");
    a_master_allow: assert property ( // see RQ16
        wr_req && hit_cs && cfg_be_in[0] |=> ##1 bus_master_allow_out
                                              == $past(cfg_wdata_in[CMD_MASTER], 2))
        else $error("bus master enable not following command");
    a_mem_gate: assert property ( // see RQ17
        !command[CMD_MEM] && !retry_pend |=> devsel_n_out)
        else $error("select while memory space disabled");

    c_line_write: cover property (wr_req && hit_li && cfg_be_in[0]);
    c_fast_select: cover property (fast_sel ##1 !devsel_n_out);
    c_flag_clear: cover property (mst_flag.value ##1 mst_flag.clear);
    c_serr_driven: cover property (serr_drive);
endmodule // cfg_header_regs

// ### cfg_header_pkg.sv
// constants for the configuration header register bank
// assumes config-cycle dword offsets arrive as byte addresses
package cfg_header_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_IDENTITY   = 8'h00;
    localparam logic [7:0] OFF_CMD_STATUS = 8'h04;
    localparam logic [7:0] OFF_LAT_INT    = 8'h3c;
    // function carried on config address bits 10:8
    localparam int         FUNC_LO        = 8;
    localparam int         FUNC_HI        = 10;
    localparam logic [2:0] NATIVE_FUNC    = 3'h1;
    // latency_interrupt_cfg fields
    localparam int         LAT_LIMIT_LO   = 24;
    localparam int         MIN_GRANT_LO   = 16;
    localparam int         INT_PIN_LO     = 8;
    localparam logic [7:0] INT_PIN_INTA   = 8'h01;
    localparam logic [7:0] INT_LINE_RESET = 8'hff;
    localparam logic [7:0] INT_LINE_MAXIRQ = 8'h0f;
    // identity fields
    localparam int         CHIP_LO        = 19;
    localparam int         FUNC_FIELD_LO  = 16;
    // command bits
    localparam int         CMD_IO         = 0;
    localparam int         CMD_MEM        = 1;
    localparam int         CMD_MASTER     = 2;
    localparam int         CMD_LINE_WRITE = 4;
    localparam int         CMD_SERR_EN    = 8;
    localparam logic [15:0] CMD_WRITE_MASK = 16'h0117;
    localparam logic [15:0] CMD_RESET      = 16'h0000;
    // status bits
    localparam int         STS_TGT_ABORT  = 28;
    localparam int         STS_MST_ABORT  = 29;
    localparam int         STS_SERR       = 30;
    localparam int         STS_SEL_LO     = 25;
    localparam logic [1:0] SEL_SPEED_FAST = 2'h0;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
endpackage

// ### flag_if.sv
// carrier between the bank and one sticky status flag
// assumes a single clock domain shared by both ends
`timescale 1ns/1ps
interface flag_if;
    logic set;
    logic clear;
    logic value;
    modport keeper (input set, input clear, output value);
    modport user   (output set, output clear, input value);
endinterface // flag_if

// ### sticky_flag.sv
// one sticky status flag, cleared by writing one
// assumes set and clear are synchronous single-cycle levels
`timescale 1ns/1ps
module sticky_flag (
    input  wire logic  clock_in,
    input  wire logic  reset_n_in,
    flag_if.keeper     port
);
    logic next_value;

    // set beats clear so a same-cycle event is not lost
    assign next_value = port.set | (port.value & ~port.clear);

    // flag storage
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            port.value <= 1'b0;
        end else begin
            port.value <= next_value;
        end
    end

    a_set_beats_clear: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        port.set |=> port.value)
        else $error("flag lost a set event");
    a_clear_takes: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        port.clear && !port.set |=> !port.value)
        else $error("flag did not clear");
endmodule // sticky_flag

// ### cfg_host_model.sv
// host bridge model that issues configuration cycles to the header bank
// assumes callers enter access at a falling edge of clock_in
`timescale 1ns/1ps
module cfg_host_model (
    input  wire logic        clock_in,
    input  wire logic        cfg_ack_in,
    input  wire logic [31:0] cfg_rdata_in,
    output logic             cfg_valid_out,
    output logic             cfg_write_out,
    output logic [10:0]      cfg_addr_out,
    output logic [3:0]       cfg_be_out,
    output logic [31:0]      cfg_wdata_out
);
    // ****************************************
    // config cycle driver
    // ****************************************
    // idle bus at time zero
    initial begin
        cfg_valid_out = 1'b0;
        cfg_write_out = 1'b0;
        cfg_addr_out  = 11'h000;
        cfg_be_out    = 4'h0;
        cfg_wdata_out = 32'h0000_0000;
    end

    // one request, answer taken a cycle later; address and write data then flip so a
    // stale value never passes for a live one
    task automatic access(input logic wr, input logic [10:0] addr, input logic [3:0] be,
                          input logic [31:0] data, output logic ack,
                          output logic [31:0] rdata);
        cfg_valid_out = 1'b1;
        cfg_write_out = wr;
        cfg_addr_out  = addr;
        cfg_be_out    = be;
        cfg_wdata_out = data;
        @(negedge clock_in);
        ack           = cfg_ack_in;
        rdata         = cfg_rdata_in;
        cfg_valid_out = 1'b0;
        cfg_addr_out  = ~cfg_addr_out;
        cfg_wdata_out = ~cfg_wdata_out;
        @(negedge clock_in);
    endtask
endmodule // cfg_host_model

// ### cfg_header_regs_test.sv
// self-checking bench for the configuration header bank
// assumes the host model and the bank share one 25 MHz clock
`timescale 1ns/1ps
module cfg_header_regs_test;
    import cfg_header_pkg::*;
    // ****************************************
    // set-up
    // ****************************************
    localparam logic [12:0] CHIP    = 13'h1234; // arbitrary value
    localparam logic [15:0] MAKER   = 16'hc3c3; // arbitrary value
    localparam logic [15:0] LG      = 16'h1234; // latency limit, min grant
    localparam logic [10:0] A_ID    = {NATIVE_FUNC, OFF_IDENTITY};
    localparam logic [10:0] A_CS    = {NATIVE_FUNC, OFF_CMD_STATUS};
    localparam logic [10:0] A_LAT   = {NATIVE_FUNC, OFF_LAT_INT};
    localparam logic [31:0] ID_WORD = {CHIP, NATIVE_FUNC, MAKER};
    typedef struct packed {
        logic wr; logic [3:0] be; logic [10:0] addr; logic [31:0] wdata; logic [31:0] exp;
    } row_t;
    logic        clock_in, reset_n_in, cfg_valid, cfg_write, ack, got_ack;
    logic        serr_req, mabort, special, tabort, hit, retry;
    logic        serr_n, serr_oe_n, devsel_n, io_ok, mem_ok, mst_ok, lw_ok;
    logic [10:0] cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, rdata, got;
    logic [2:0]  seq;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cycles = 0;
    row_t        rows [12];

    cfg_header_regs #(.CHIP_NUMBER(CHIP), .MAKER_CODE(MAKER), .LATENCY_LIMIT(LG[15:8]),
                      .MIN_GRANT(LG[7:0])) u_dut (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .cfg_valid_in(cfg_valid),
        .cfg_write_in(cfg_write), .cfg_addr_in(cfg_addr), .cfg_be_in(cfg_be),
        .cfg_wdata_in(cfg_wdata), .serr_request_in(serr_req), .master_abort_in(mabort),
        .special_cycle_in(special), .target_abort_in(tabort), .target_hit_in(hit),
        .retry_in(retry), .cfg_ack_out(ack), .cfg_rdata_out(rdata), .serr_n_out(serr_n),
        .serr_oe_n_out(serr_oe_n), .devsel_n_out(devsel_n), .io_space_allow_out(io_ok),
        .mem_space_allow_out(mem_ok), .bus_master_allow_out(mst_ok),
        .line_write_cmd_allow_out(lw_ok));
    cfg_host_model u_host (
        .clock_in(clock_in), .cfg_ack_in(ack), .cfg_rdata_in(rdata),
        .cfg_valid_out(cfg_valid), .cfg_write_out(cfg_write), .cfg_addr_out(cfg_addr),
        .cfg_be_out(cfg_be), .cfg_wdata_out(cfg_wdata));

    // ****************************************
    // clock, timeout and helpers
    // ****************************************
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    // the whole run needs under a hundred cycles; a hang stops at cycle 3000
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            results();
        end
    end
    task automatic chk_word(input string name, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask
    // one config cycle: answer must come, read data as expected (writes give zero)
    task automatic xfer(input logic wr, input logic [10:0] a, input logic [3:0] be,
                        input logic [31:0] d, input logic [31:0] e);
        u_host.access(wr, a, be, d, got_ack, got);
        chk_word("cfg_ack", 32'h0000_0001, {31'h0, got_ack});
        chk_word("cfg_rdata", e, got);
    endtask
    // event pulse as {master abort, special cycle, target abort}
    task automatic pulse(input logic [2:0] ev);
        {mabort, special, tabort} = ev;
        @(negedge clock_in);
        {mabort, special, tabort} = 3'h0;
        @(negedge clock_in);
    endtask
    // select strobe, then three cycles of the select pin, earliest in the top bit
    task automatic sel(input logic rt);
        hit   = 1'b1;
        retry = rt;
        @(negedge clock_in);
        hit    = 1'b0;
        retry  = 1'b0;
        seq[2] = devsel_n;
        @(negedge clock_in);
        seq[1] = devsel_n;
        @(negedge clock_in);
        seq[0] = devsel_n;
    endtask
    task automatic results();
        $display("counts: %0d checks, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        reset_n_in = 1'b0;
        {serr_req, mabort, special, tabort, hit, retry} = 6'h00;
        rows = '{
            '{1'b0, 4'h0, A_LAT, ZERO_WORD, {LG, INT_PIN_INTA, INT_LINE_RESET}},
            '{1'b0, 4'h0, {3'h0, OFF_LAT_INT}, ZERO_WORD, {16'h0, INT_PIN_INTA, INT_LINE_RESET}},
            '{1'b0, 4'h0, A_ID, ZERO_WORD, ID_WORD},
            '{1'b0, 4'h0, A_CS, ZERO_WORD, ZERO_WORD},
            '{1'b1, 4'hf, A_LAT, 32'hffff_ff0f, ZERO_WORD},
            '{1'b0, 4'h0, A_LAT, ZERO_WORD, {LG, INT_PIN_INTA, INT_LINE_MAXIRQ}},
            '{1'b1, 4'hf, A_ID, 32'hffff_ffff, ZERO_WORD},
            '{1'b0, 4'h0, A_ID, ZERO_WORD, ID_WORD},
            '{1'b0, 4'h0, {3'h2, OFF_IDENTITY}, ZERO_WORD, ZERO_WORD},
            '{1'b0, 4'h0, {NATIVE_FUNC, 8'h08}, ZERO_WORD, ZERO_WORD},
            '{1'b1, 4'h1, {3'h0, OFF_LAT_INT}, ZERO_WORD, ZERO_WORD},
            '{1'b0, 4'h0, A_LAT, ZERO_WORD, {LG, INT_PIN_INTA, 8'h00}}};
        repeat (4) @(negedge clock_in);
        chk_word("pins_in_reset", 32'h0000_0007, {29'h0, serr_n, serr_oe_n, devsel_n});
        repeat (4) @(negedge clock_in);
        reset_n_in = 1'b1;
        chk_word("allow_reset", ZERO_WORD, {28'h0, lw_ok, mst_ok, mem_ok, io_ok});
        $display("test reset done");
        foreach (rows[i]) begin
            xfer(rows[i].wr, rows[i].addr, rows[i].be, rows[i].wdata, rows[i].exp);
        end
        $display("test rows done");
        xfer(1'b1, A_CS, 4'h3, 32'h0000_ffff, ZERO_WORD);
        xfer(1'b0, A_CS, 4'h0, ZERO_WORD, 32'h0000_0117);
        chk_word("allow_on", 32'h0000_000f, {28'h0, lw_ok, mst_ok, mem_ok, io_ok});
        sel(1'b0);
        chk_word("devsel_fast", 32'h0000_0003, {29'h0, seq});
        sel(1'b1);
        chk_word("devsel_retry", 32'h0000_0005, {29'h0, seq});
        serr_req = 1'b1;
        @(negedge clock_in);
        chk_word("serr_driven", ZERO_WORD, {30'h0, serr_n, serr_oe_n});
        serr_req = 1'b0;
        @(negedge clock_in);
        chk_word("serr_release", 32'h0000_0003, {30'h0, serr_n, serr_oe_n});
        pulse(3'b110);
        xfer(1'b0, A_CS, 4'h0, ZERO_WORD, 32'h4000_0117);
        pulse(3'b100);
        pulse(3'b001);
        xfer(1'b0, A_CS, 4'h0, ZERO_WORD, 32'h7000_0117);
        xfer(1'b1, A_CS, 4'h8, 32'h7000_0000, ZERO_WORD);
        xfer(1'b0, A_CS, 4'h0, ZERO_WORD, 32'h0000_0117);
        $display("test status done");
        // everything off: no select, no error drive, no flag
        xfer(1'b1, A_CS, 4'h3, ZERO_WORD, ZERO_WORD);
        serr_req = 1'b1;
        sel(1'b0);
        chk_word("devsel_off", 32'h0000_0007, {29'h0, seq});
        chk_word("serr_off", 32'h0000_0003, {30'h0, serr_n, serr_oe_n});
        serr_req = 1'b0;
        chk_word("allow_off", ZERO_WORD, {28'h0, lw_ok, mst_ok, mem_ok, io_ok});
        xfer(1'b0, A_CS, 4'h0, ZERO_WORD, ZERO_WORD);
        // mid-run reset brings the line back to unconnected
        reset_n_in = 1'b0;
        @(negedge clock_in);
        reset_n_in = 1'b1;
        xfer(1'b0, A_LAT, 4'h0, ZERO_WORD, {LG, INT_PIN_INTA, INT_LINE_RESET});
        $display("test disable and reset done");
        results();
    end
endmodule // cfg_header_regs_test
